// ### inc/tcc_pkg.sv
// Constants shared by the timer counter core: register map, fields, resets
`default_nettype none
package tcc_pkg;
    // Register byte addresses on the bus (one aligned word each)
    localparam logic [7:0] TCC_OFS_TIMER_SC = 8'h00;
    localparam logic [7:0] TCC_OFS_CNT_HIGH = 8'h04;
    localparam logic [7:0] TCC_OFS_CNT_LOW = 8'h08;
    localparam logic [7:0] TCC_OFS_MOD_HIGH = 8'h0c;
    localparam logic [7:0] TCC_OFS_MOD_LOW = 8'h10;
    // Channel n block starts at CH_BASE + n * CH_STRIDE
    localparam logic [7:0] TCC_OFS_CH_BASE = 8'h20;
    localparam logic [7:0] TCC_OFS_CH_STRIDE = 8'h10;
    // Word index of each register inside a channel block
    localparam logic [1:0] TCC_CH_IDX_SC = 2'h0;
    localparam logic [1:0] TCC_CH_IDX_VAL_HIGH = 2'h1;
    localparam logic [1:0] TCC_CH_IDX_VAL_LOW = 2'h2;
    // Timer status/control field positions
    localparam int TCC_TSC_OVF_BIT = 7;
    localparam int TCC_TSC_OVIE_BIT = 6;
    localparam int TCC_TSC_CPWM_BIT = 5;
    localparam int TCC_TSC_CLKB_BIT = 4;
    localparam int TCC_TSC_CLKA_BIT = 3;
    // Channel status/control field positions
    localparam int TCC_CSC_MSB_BIT = 5;
    localparam int TCC_CSC_MSA_BIT = 4;
    localparam int TCC_CSC_ELSB_BIT = 3;
    localparam int TCC_CSC_ELSA_BIT = 2;
    // Clock source select codes (select_b:select_a)
    localparam logic [1:0] TCC_CLK_OFF = 2'h0;
    localparam logic [1:0] TCC_CLK_BUS = 2'h1;
    localparam logic [1:0] TCC_CLK_FIXED = 2'h2;
    localparam logic [1:0] TCC_CLK_EXT = 2'h3;
    // Channel mode codes shown on o_ch_mode
    localparam logic [1:0] TCC_MODE_CAPTURE = 2'h0;
    localparam logic [1:0] TCC_MODE_COMPARE = 2'h1;
    localparam logic [1:0] TCC_MODE_EPWM = 2'h2;
    localparam logic [1:0] TCC_MODE_CPWM = 2'h3;
    // Reset values and counter limits
    localparam logic [1:0] TCC_RST_CLK_SRC = 2'h0;
    localparam logic [15:0] TCC_RST_VALUE = 16'h0000;
    localparam logic [15:0] TCC_RST_MODULO = 16'h0000;
    localparam logic [3:0] TCC_RST_CH_SC = 4'h0;
    localparam logic [15:0] TCC_CNT_ZERO = 16'h0000;
    localparam logic [15:0] TCC_CNT_FULL = 16'hffff;
    // External clock may run at most bus rate divided by this
    localparam int TCC_EXT_CLK_DIV_MIN = 4;
    localparam int TCC_MAX_CH = 8;
endpackage
`default_nettype wire

// ### tb/tcc_ext_clk_model.sv
// External clock pin model driving the timer core's clock input
`default_nettype none
module tcc_ext_clk_model (
    input wire logic i_clk,
    input wire logic i_en,
    output logic o_ext_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q;
    // Toggle every 4 bus cycles: an eighth of bus rate, under the limit
    always_ff @(posedge i_clk) begin
        if (!i_en) begin
            div_q <= 2'h0;
            o_ext_clk <= 1'b0; // Pin rests low between bursts
        end else begin
            div_q <= div_q + 2'h1;
            if (div_q == 2'h3) o_ext_clk <= ~o_ext_clk;
        end
    end
endmodule
`default_nettype wire

// ### tb/timer_counter_core_coherency_bench.sv
// Bus-level tests of the timer counter core
`default_nettype none
module timer_counter_core_coherency_bench;
    import tcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic [7:0] i_address = 8'h00;
    logic [31:0] i_writedata = 32'h0, o_readdata;
    logic o_waitrequest, i_fixed_clk_tick = 1'b0, i_ext_clk;
    logic i_debug_halt = 1'b0, i_stop_mode = 1'b0, o_irq, o_count_down;
    logic ext_en = 1'b0;
    logic ce = 1'b1;
    int nz;
    logic [1:0] tick_q = 2'h0;
    logic [15:0] o_count, mx, c;
    logic [3:0] o_ch_mode;
    logic [1:0] o_pin_timer_use;
    logic [7:0] r, l1, sc_tab [4];
    logic dn, irq_seen;
    int n_fail = 0, checked = 0;
    tcc_timer_core #(.NUM_CH(2)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_ce(ce), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata),
        .i_byteenable(4'h1), .o_readdata(o_readdata),
        .o_waitrequest(o_waitrequest), .i_fixed_clk_tick(i_fixed_clk_tick),
        .i_ext_clk(i_ext_clk), .i_debug_halt(i_debug_halt),
        .i_stop_mode(i_stop_mode), .o_irq(o_irq), .o_count(o_count),
        .o_count_down(o_count_down), .o_ch_mode(o_ch_mode),
        .o_pin_timer_use(o_pin_timer_use));
    tcc_ext_clk_model ext (.i_clk(i_clk), .i_en(ext_en),
        .o_ext_clk(i_ext_clk));
    // 100 MHz clock
    always #5 i_clk = ~i_clk;
    // Fixed clock tick every fourth cycle
    always @(posedge i_clk) begin
        tick_q <= tick_q + 2'h1;
        i_fixed_clk_tick <= (tick_q == 2'h3);
    end
    // Request held until waitrequest is seen low at a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_address <= a;
        i_writedata <= {24'h0, d};
        i_write <= 1'b1;
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        i_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_address <= a;
        i_read <= 1'b1;
        do @(posedge i_clk); while (o_waitrequest !== 1'b0);
        d = o_readdata[7:0];
        i_read <= 1'b0;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Sample counter, direction and interrupt between edges
    task automatic watch(input int n);
        mx = 16'h0;
        dn = 1'b0;
        irq_seen = 1'b0;
        nz = 0;
        repeat (n) begin
            @(negedge i_clk);
            if (o_count > mx) mx = o_count;
            if (o_count == 16'h0) nz++;
            dn = dn | o_count_down;
            irq_seen = irq_seen | o_irq;
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
    initial begin
        sc_tab = '{8'h04, 8'h14, 8'h24, 8'h00};
        repeat (4) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(8'h00, r); chk(r, 8'h00);
        rd(8'h24, r); chk(r, 8'h00);
        rd(8'h28, r); chk(r, 8'h00);
        rd(8'hfc, r); chk(r, 8'h00);
        watch(10); chk(mx, 16'h0);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            wr(8'h20, sc_tab[i]);
            repeat (2) @(posedge i_clk);
            chk(o_ch_mode[1:0], (i == 3) ? 2'h0 : i[1:0]);
            chk(o_pin_timer_use[0], (i != 3));
        end
        wr(8'h00, 8'h20);
        repeat (2) @(posedge i_clk);
        chk(o_ch_mode, 4'hf);
        wr(8'h00, 8'h00);
        $display("mode test done");
        wr(8'h30, 8'h14);
        wr(8'h38, 8'h22);
        wr(8'h34, 8'h11);
        rd(8'h34, r); chk(r, 8'h11);
        rd(8'h38, r); chk(r, 8'h22);
        wr(8'h34, 8'h33);
        wr(8'h30, 8'h14);
        wr(8'h38, 8'h44);
        wr(8'h34, 8'h55);
        rd(8'h34, r); chk(r, 8'h55);
        rd(8'h38, r); chk(r, 8'h44);
        $display("value test done");
        // Channel 0 sits in capture mode: writes land, reads latch
        wr(8'h24, 8'h12);
        wr(8'h28, 8'h34);
        rd(8'h24, r); chk(r, 8'h12);
        wr(8'h28, 8'h56);
        rd(8'h28, r); chk(r, 8'h34);
        rd(8'h24, r); chk(r, 8'h12);
        wr(8'h28, 8'h78);
        wr(8'h20, 8'h00);
        rd(8'h28, r); chk(r, 8'h78);
        rd(8'h24, r); chk(r, 8'h12);
        $display("capture test done");
        wr(8'h10, 8'h04);
        wr(8'h00, 8'h48);
        watch(30); chk(mx, 16'h4);
        chk(irq_seen, 1'b1);
        rd(8'h00, r); chk(r[7], 1'b1);
        wr(8'h00, 8'h08);
        watch(30); chk(irq_seen, 1'b0);
        $display("overflow test done");
        wr(8'h10, 8'h00);
        wr(8'h04, 8'h00);
        rd(8'h08, l1); chk(l1 < 8'h06, 1'b1);
        repeat (10) @(posedge i_clk);
        rd(8'h08, r); chk(r, l1);
        rd(8'h04, r);
        rd(8'h08, r); chk(r === l1, 1'b0);
        $display("snapshot test done");
        i_debug_halt <= 1'b1;
        repeat (3) @(posedge i_clk);
        c = o_count;
        repeat (10) @(posedge i_clk);
        chk(o_count, c);
        i_debug_halt <= 1'b0;
        i_stop_mode <= 1'b1;
        repeat (3) @(posedge i_clk);
        c = o_count;
        repeat (10) @(posedge i_clk);
        chk(o_count, c);
        i_stop_mode <= 1'b0;
        // Clock enable low must freeze the counter as well
        ce <= 1'b0;
        repeat (10) @(posedge i_clk);
        chk(o_count, c);
        ce <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk(o_count === c, 1'b0);
        $display("halt test done");
        wr(8'h10, 8'h03);
        wr(8'h00, 8'h28);
        // Count is far above the modulo here, so restart it from zero
        wr(8'h04, 8'h00);
        watch(30); chk(mx, 16'h3);
        chk(dn, 1'b1);
        chk(nz > 3 && nz < 7, 1'b1);
        rd(8'h00, r); chk(r[7], 1'b1);
        $display("up down test done");
        wr(8'h10, 8'h00);
        wr(8'h00, 8'h10);
        wr(8'h08, 8'h00);
        watch(40); chk(mx > 16'h7 && mx < 16'hc, 1'b1);
        ext_en <= 1'b1;
        wr(8'h00, 8'h18);
        wr(8'h08, 8'h00);
        watch(64); chk(mx > 16'h4 && mx < 16'ha, 1'b1);
        ext_en <= 1'b0;
        $display("clock source test done");
        stop_test();
    end
endmodule
`default_nettype wire

// ### verilog/tcc_timer_core.sv
// Timer counter core: main counter, modulo, overflow, coherent byte access
//
// Function
// - Reset clears both bytes of every channel value register.
// - Capture mode: reading one value byte freezes both until other read.
// - Writing channel status/control releases that channel's read latch.
// - Compare/PWM: value byte writes buffer; pair moves to active together.
// - Channel status/control write discards a half-written value pair.
// - Value high and low bytes may be written in either order.
// - One 16-bit main counter shared by channels, with 16-bit modulo.
// - Center-PWM select 1: counter up/down, all channels center PWM.
// - Center-PWM select 0: channels independently capture, compare, PWM.
// - After reset clock source select reads 0:0, timer inactive.
// - Clock select: off, bus clock 0:1, fixed system clock, external.
// - Debug halt pauses counting; counting resumes afterwards.
// - Stop mode halts the timer; wait mode runs as normal.
// - Up mode counts zero to terminal, wraps; terminal 0xffff or modulo.
// - Up/down counts zero to modulo and back; ends last one tick.
// - Overflow enable 1 gives level interrupt while flag set.
// - Up mode: overflow flag sets on wrap from terminal to zero.
// - Up/down mode: overflow flag sets stepping down from modulo.
// - Counter byte read snapshots both bytes until both are read.
// - Counter byte write clears counter and any half-read snapshot.
// - Mode select bits choose channel mode when center-PWM is 0.
// - Mode B set gives edge PWM; else A picks capture or compare.
// - Edge/level bits both 0 release the channel pin from timer use.
`default_nettype none
module tcc_timer_core
    import tcc_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    input wire logic i_fixed_clk_tick,
    input wire logic i_ext_clk,
    input wire logic i_debug_halt,
    input wire logic i_stop_mode,
    output logic o_irq,
    output logic [15:0] o_count,
    output logic o_count_down,
    output logic [2*NUM_CH-1:0] o_ch_mode,
    output logic [NUM_CH-1:0] o_pin_timer_use
);

    // Channel blocks must fit in the 8-bit address space
    if (NUM_CH < 1 || NUM_CH > TCC_MAX_CH) begin : g_bad_num_ch
        $error("NUM_CH must lie between 1 and 8");
    end

    // Bus slave: one wait cycle; the access acts on its first edge
    logic wait_q;
    logic fire;
    logic rd_fire;
    logic wr_fire;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    assign fire = i_ce && wait_q && (i_read || i_write);
    assign rd_fire = fire && i_read;
    assign wr_fire = fire && i_write && i_byteenable[0];
    assign wr_byte = i_writedata[7:0];

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wait_q <= 1'b1;
        end else if (i_ce) begin
            wait_q <= !(wait_q && (i_read || i_write));
        end
    end

    // Data is registered at the same edge that applies read side effects
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_readdata <= 32'h0000_0000;
        end else if (rd_fire) begin
            o_readdata <= {24'h00_0000, rd_byte};
        end
    end
    assign o_waitrequest = wait_q;

    // Timer status/control
    logic ovf_q;
    logic ovie_q;
    logic cpwm_q;
    logic [1:0] clk_src_q;
    logic [15:0] mod_q;
    logic sel_tsc;
    logic sel_cnt_hi;
    logic sel_cnt_lo;
    logic cnt_wr;
    logic ovf_set;
    assign sel_tsc = i_address[7:2] == TCC_OFS_TIMER_SC[7:2];
    assign sel_cnt_hi = i_address[7:2] == TCC_OFS_CNT_HIGH[7:2];
    assign sel_cnt_lo = i_address[7:2] == TCC_OFS_CNT_LOW[7:2];
    assign cnt_wr = wr_fire && (sel_cnt_hi || sel_cnt_lo);

    // Software writes 0 to the flag to clear it; a new overflow wins
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ovf_q <= 1'b0;
            ovie_q <= 1'b0;
            cpwm_q <= 1'b0;
            clk_src_q <= TCC_RST_CLK_SRC;
        end else if (i_ce) begin
            if (wr_fire && sel_tsc) begin
                ovie_q <= wr_byte[TCC_TSC_OVIE_BIT];
                cpwm_q <= wr_byte[TCC_TSC_CPWM_BIT];
                clk_src_q <= {wr_byte[TCC_TSC_CLKB_BIT],
                              wr_byte[TCC_TSC_CLKA_BIT]};
            end
            if (ovf_set) begin
                ovf_q <= 1'b1;
            end else if (wr_fire && sel_tsc && !wr_byte[TCC_TSC_OVF_BIT]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    // Modulo bytes; buffering of modulo writes is not provided
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            mod_q <= TCC_RST_MODULO;
        end else if (wr_fire) begin
            if (i_address[7:2] == TCC_OFS_MOD_HIGH[7:2]) begin
                mod_q[15:8] <= wr_byte;
            end
            if (i_address[7:2] == TCC_OFS_MOD_LOW[7:2]) begin
                mod_q[7:0] <= wr_byte;
            end
        end
    end

    // External clock pin: two flops, then an edge detect on the second
    logic ext_meta_q;
    logic ext_sync_q;
    logic ext_prev_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else if (i_ce) begin
            ext_meta_q <= i_ext_clk;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
        end
    end

    // Tick choice; the edge detect only sees slow clocks cleanly
    logic src_tick;
    logic tick;
    always_comb begin
        unique case (clk_src_q)
            TCC_CLK_BUS: src_tick = 1'b1;
            TCC_CLK_FIXED: src_tick = i_fixed_clk_tick;
            TCC_CLK_EXT: src_tick = ext_sync_q && !ext_prev_q;
            default: src_tick = 1'b0;
        endcase
    end
    // Wait mode has no input, so it counts as in run mode
    assign tick = i_ce && src_tick && !i_debug_halt && !i_stop_mode;

    // Main counter; the modulo value 0 means free running to 0xffff
    logic [15:0] cnt_q;
    logic down_q;
    logic [15:0] term;
    logic at_term;
    assign term = (mod_q == TCC_CNT_ZERO) ? TCC_CNT_FULL : mod_q;
    assign at_term = cnt_q == term;
    assign ovf_set = tick && !cnt_wr && at_term && (!cpwm_q || !down_q);

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_q <= TCC_CNT_ZERO;
            down_q <= 1'b0;
        end else if (cnt_wr) begin
            cnt_q <= TCC_CNT_ZERO;
            down_q <= 1'b0;
        end else if (tick) begin
            if (!cpwm_q) begin
                down_q <= 1'b0;
                cnt_q <= at_term ? TCC_CNT_ZERO : cnt_q + 16'h0001;
            end else if (!down_q) begin
                // Terminal state lasts one tick, then the count turns
                down_q <= at_term;
                cnt_q <= at_term ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
            end else begin
                // Zero lasts one tick, then the count turns upward
                down_q <= cnt_q != TCC_CNT_ZERO;
                cnt_q <= (cnt_q == TCC_CNT_ZERO) ? cnt_q + 16'h0001
                                                 : cnt_q - 16'h0001;
            end
        end
    end

    // Counter read snapshot; the first byte read decides which closes it
    logic cnt_hold_q;
    logic cnt_first_hi_q;
    logic [15:0] cnt_lat_q;
    logic [15:0] cnt_view;
    assign cnt_view = cnt_hold_q ? cnt_lat_q : cnt_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            cnt_hold_q <= 1'b0;
            cnt_first_hi_q <= 1'b0;
            cnt_lat_q <= TCC_CNT_ZERO;
        end else if (cnt_wr) begin
            cnt_hold_q <= 1'b0;
        end else if (rd_fire && (sel_cnt_hi || sel_cnt_lo)) begin
            if (!cnt_hold_q) begin
                cnt_hold_q <= 1'b1;
                cnt_first_hi_q <= sel_cnt_hi;
                cnt_lat_q <= cnt_q;
            end else if (sel_cnt_hi != cnt_first_hi_q) begin
                cnt_hold_q <= 1'b0;
            end
        end
    end

    // Per-channel state, visible to the read mux and the checks
    logic [3:0] ch_sc_q [NUM_CH];
    logic [15:0] ch_val_q [NUM_CH];
    logic [15:0] ch_lat_q [NUM_CH];
    logic [NUM_CH-1:0] ch_hold_q;
    logic [NUM_CH-1:0] ch_cap;
    logic [NUM_CH-1:0] ch_commit;
    logic [NUM_CH-1:0] ch_sc_wr;
    logic [1:0] ch_pend_q [NUM_CH];

    for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
        logic sel;
        logic [1:0] idx;
        logic wr_hi;
        logic wr_lo;
        logic rd_val;
        logic [15:0] wbuf_q;
        logic [1:0] mode;
        assign sel = i_address[7:4] == 4'(TCC_OFS_CH_BASE[7:4] + n);
        assign idx = i_address[3:2];
        assign wr_hi = wr_fire && sel && idx == TCC_CH_IDX_VAL_HIGH;
        assign wr_lo = wr_fire && sel && idx == TCC_CH_IDX_VAL_LOW;
        assign rd_val = rd_fire && sel && (idx == TCC_CH_IDX_VAL_HIGH ||
                                           idx == TCC_CH_IDX_VAL_LOW);
        assign ch_sc_wr[n] = wr_fire && sel && idx == TCC_CH_IDX_SC;
        // Both bytes present after this write completes the pair
        assign ch_commit[n] = !ch_cap[n] && !ch_sc_wr[n] &&
            ((wr_hi && (ch_pend_q[n][0] || wr_lo)) ||
             (wr_lo && ch_pend_q[n][1]));

        // Mode decode; center PWM overrides every channel
        always_comb begin
            if (cpwm_q) begin
                mode = TCC_MODE_CPWM;
            end else if (ch_sc_q[n][TCC_CSC_MSB_BIT-2]) begin
                mode = TCC_MODE_EPWM;
            end else if (ch_sc_q[n][TCC_CSC_MSA_BIT-2]) begin
                mode = TCC_MODE_COMPARE;
            end else begin
                mode = TCC_MODE_CAPTURE;
            end
        end
        assign ch_cap[n] = mode == TCC_MODE_CAPTURE;

        // Channel status/control
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                ch_sc_q[n] <= TCC_RST_CH_SC;
            end else if (ch_sc_wr[n]) begin
                ch_sc_q[n] <= wr_byte[TCC_CSC_MSB_BIT:TCC_CSC_ELSA_BIT];
            end
        end

        // Write pairing; a status/control write drops a half pair
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                ch_pend_q[n] <= 2'h0;
                wbuf_q <= TCC_RST_VALUE;
            end else if (ch_sc_wr[n] || ch_commit[n]) begin
                ch_pend_q[n] <= 2'h0;
            end else if (!ch_cap[n] && (wr_hi || wr_lo)) begin
                if (wr_hi) begin
                    ch_pend_q[n][1] <= 1'b1;
                    wbuf_q[15:8] <= wr_byte;
                end else begin
                    ch_pend_q[n][0] <= 1'b1;
                    wbuf_q[7:0] <= wr_byte;
                end
            end
        end

        // Active value; capture mode writes land directly
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                ch_val_q[n] <= TCC_RST_VALUE;
            end else if (ch_commit[n]) begin
                ch_val_q[n] <= wr_hi ? {wr_byte, wbuf_q[7:0]}
                                     : {wbuf_q[15:8], wr_byte};
            end else if (ch_cap[n] && wr_hi) begin
                ch_val_q[n][15:8] <= wr_byte;
            end else if (ch_cap[n] && wr_lo) begin
                ch_val_q[n][7:0] <= wr_byte;
            end
        end

        // Capture read latch, same scheme as the counter snapshot
        logic first_hi_q;
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                ch_hold_q[n] <= 1'b0;
                first_hi_q <= 1'b0;
                ch_lat_q[n] <= TCC_RST_VALUE;
            end else if (ch_sc_wr[n]) begin
                ch_hold_q[n] <= 1'b0;
            end else if (rd_val && ch_cap[n]) begin
                if (!ch_hold_q[n]) begin
                    ch_hold_q[n] <= 1'b1;
                    first_hi_q <= idx == TCC_CH_IDX_VAL_HIGH;
                    ch_lat_q[n] <= ch_val_q[n];
                end else if ((idx == TCC_CH_IDX_VAL_HIGH) != first_hi_q) begin
                    ch_hold_q[n] <= 1'b0;
                end
            end
        end

        // Mode and pin use are registered for clean outputs
        always_ff @(posedge i_clk) begin
            if (!i_rst_b) begin
                o_ch_mode[2*n +: 2] <= TCC_MODE_CAPTURE;
                o_pin_timer_use[n] <= 1'b0;
            end else if (i_ce) begin
                o_ch_mode[2*n +: 2] <= mode;
                o_pin_timer_use[n] <= |ch_sc_q[n][1:0];
            end
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        logic [15:0] v;
        logic [3:0] k;
        v = TCC_CNT_ZERO;
        k = 4'h0;
        rd_byte = 8'h00;
        if (sel_tsc) begin
            rd_byte[TCC_TSC_OVF_BIT] = ovf_q;
            rd_byte[TCC_TSC_OVIE_BIT] = ovie_q;
            rd_byte[TCC_TSC_CPWM_BIT] = cpwm_q;
            rd_byte[TCC_TSC_CLKB_BIT] = clk_src_q[1];
            rd_byte[TCC_TSC_CLKA_BIT] = clk_src_q[0];
        end else if (sel_cnt_hi) begin
            rd_byte = cnt_view[15:8];
        end else if (sel_cnt_lo) begin
            rd_byte = cnt_view[7:0];
        end else if (i_address[7:2] == TCC_OFS_MOD_HIGH[7:2]) begin
            rd_byte = mod_q[15:8];
        end else if (i_address[7:2] == TCC_OFS_MOD_LOW[7:2]) begin
            rd_byte = mod_q[7:0];
        end else if (i_address[7:4] >= TCC_OFS_CH_BASE[7:4]) begin
            k = i_address[7:4] - TCC_OFS_CH_BASE[7:4];
            for (int n = 0; n < NUM_CH; n++) begin
                if (k == 4'(n)) begin
                    v = (ch_cap[n] && ch_hold_q[n]) ? ch_lat_q[n]
                                                    : ch_val_q[n];
                    unique case (i_address[3:2])
                        TCC_CH_IDX_SC: rd_byte = {2'h0, ch_sc_q[n], 2'h0};
                        TCC_CH_IDX_VAL_HIGH: rd_byte = v[15:8];
                        TCC_CH_IDX_VAL_LOW: rd_byte = v[7:0];
                        default: rd_byte = 8'h00;
                    endcase
                end
            end
        end
    end

    // Level interrupt follows the flag while enabled
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= ovf_q && ovie_q;
        end
    end
    assign o_count = cnt_q;
    assign o_count_down = down_q;

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    property p_value_reset;
        $rose(i_rst_b) |-> ch_val_q[0] == TCC_RST_VALUE;
    endproperty
    a_value_reset: assert property (p_value_reset)
        else $error("channel value not cleared by reset");

    property p_clk_off_reset;
        $rose(i_rst_b) |-> clk_src_q == TCC_CLK_OFF && !tick;
    endproperty
    a_clk_off_reset: assert property (p_clk_off_reset)
        else $error("clock source not off after reset");

    property p_up_wrap;
        tick && !cnt_wr && !cpwm_q && at_term |=> cnt_q == 16'h0000 && ovf_q;
    endproperty
    a_up_wrap: assert property (p_up_wrap)
        else $error("up counter did not wrap with overflow");

    property p_turn;
        tick && !cnt_wr && cpwm_q && !down_q && at_term
            |=> down_q && cnt_q == $past(cnt_q) - 16'h0001 && ovf_q;
    endproperty
    a_turn: assert property (p_turn)
        else $error("up/down counter did not turn at modulo");

    property p_bottom;
        tick && !cnt_wr && cpwm_q && down_q && cnt_q == TCC_CNT_ZERO
            |=> !down_q && cnt_q == 16'h0001;
    endproperty
    a_bottom: assert property (p_bottom)
        else $error("up/down counter did not turn at zero");

    property p_paused;
        (i_debug_halt || i_stop_mode) && !cnt_wr |=> $stable(cnt_q);
    endproperty
    a_paused: assert property (p_paused)
        else $error("counter moved while halted");

    property p_irq;
        ovf_q && ovie_q && i_ce ##1 ovf_q && ovie_q |-> o_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt missing while flag enabled");

    property p_snap;
        rd_fire && (sel_cnt_hi || sel_cnt_lo) && !cnt_hold_q
            |=> cnt_hold_q && cnt_lat_q == $past(cnt_q);
    endproperty
    a_snap: assert property (p_snap)
        else $error("counter read did not snapshot");

    property p_cnt_clear;
        cnt_wr |=> cnt_q == 16'h0000 && !cnt_hold_q;
    endproperty
    a_cnt_clear: assert property (p_cnt_clear)
        else $error("counter write did not clear");

    property p_pair;
        $changed(ch_val_q[0]) && !$past(ch_cap[0]) |-> $past(ch_commit[0]);
    endproperty
    a_pair: assert property (p_pair)
        else $error("channel value changed without a full pair");

    property p_sc_restart;
        ch_sc_wr[0] |=> ch_pend_q[0] == 2'h0 && !ch_hold_q[0];
    endproperty
    a_sc_restart: assert property (p_sc_restart)
        else $error("status write left a pair pending");

    c_up_wrap: cover property (tick && !cpwm_q && at_term);
    c_turn: cover property (tick && cpwm_q && !down_q && at_term);
    c_snap_pair: cover property (cnt_hold_q ##[1:20] !cnt_hold_q);
    c_commit: cover property (ch_commit[0]);

endmodule
`default_nettype wire
